//--- design/aafc_top.sv
// Bit clock and frame clock generator with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module aafc_top
  import aafc_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [AXI_AW-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [AXI_AW-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic SECOND_BIT_CLOCK_I,
  output logic SECOND_BIT_CLOCK_O,
  output logic SECOND_BIT_CLOCK_OE_N_O,
  input wire logic TX_FRAME_CLOCK_I,
  output logic TX_FRAME_CLOCK_O,
  output logic TX_FRAME_CLOCK_OE_N_O,
  input wire logic RX_FRAME_CLOCK_I,
  output logic RX_FRAME_CLOCK_O,
  output logic RX_FRAME_CLOCK_OE_N_O,
  output logic TX_SYNC_O,
  output logic RX_SYNC_O
);

  // Register file
  aafc_bclk_ctrl_t bclk_q;
  aafc_bclk_ctrl_t bclk_d;
  logic [15:0] tx_rate_q;
  logic [15:0] tx_rate_d;
  aafc_fc_ctrl_t tx_ctrl_q;
  aafc_fc_ctrl_t tx_ctrl_d;
  logic [15:0] rx_rate_q;
  logic [15:0] rx_rate_d;
  aafc_fc_ctrl_t rx_ctrl_q;
  aafc_fc_ctrl_t rx_ctrl_d;
  logic [15:0] chan_en_q;
  logic [15:0] chan_en_d;

  // Bus handshake state
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic wr_take;
  logic rd_take;
  logic [9:0] wr_idx;
  logic [9:0] rd_idx;
  logic [15:0] rd_val;
  logic rd_hit;

  // Clock generation
  logic [BDIV_W-1:0] bclk_div_n;
  logic bdiv_tick;
  logic bdiv_level;
  logic bclk_pin_s;
  logic tx_pin_s;
  logic rx_pin_s;
  logic bclk_prev_q;
  logic ext_rise;
  logic bit_tick;
  logic tx_gen;
  logic rx_gen;
  logic tx_fs;
  logic rx_fs;
  logic chan_any;
  logic tx_drive;
  logic rx_drive;
  aafc_pin_t bclk_pin_q;
  aafc_pin_t bclk_pin_d;
  aafc_pin_t tx_pin_q;
  aafc_pin_t tx_pin_d;
  aafc_pin_t rx_pin_q;
  aafc_pin_t rx_pin_d;
  logic tx_sync_q;
  logic tx_sync_d;
  logic rx_sync_q;
  logic rx_sync_d;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] msk);
    logic [15:0] v;
    v = old;
    if (s[0])
    begin
      v[7:0] = d[7:0];
    end
    if (s[1])
    begin
      v[15:8] = d[15:8];
    end
    return v & msk;
  endfunction

  // Write address and data are taken together; one response outstanding at a time
  assign wr_take = S_AXI_AWVALID_I && S_AXI_WVALID_I && !bvalid_q;
  assign rd_take = S_AXI_ARVALID_I && !rvalid_q;
  assign wr_idx = S_AXI_AWADDR_I[11:2];
  assign rd_idx = S_AXI_ARADDR_I[11:2];
  assign S_AXI_AWREADY_O = wr_take;
  assign S_AXI_WREADY_O = wr_take;
  assign S_AXI_ARREADY_O = rd_take;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;

  always_comb
  begin
    bclk_d = bclk_q;
    tx_rate_d = tx_rate_q;
    tx_ctrl_d = tx_ctrl_q;
    rx_rate_d = rx_rate_q;
    rx_ctrl_d = rx_ctrl_q;
    chan_en_d = chan_en_q;
    bvalid_d = bvalid_q && !S_AXI_BREADY_I;
    bresp_d = bresp_q;
    if (wr_take)
    begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (wr_idx)
        IDX_BCLK_CTRL: bclk_d = merge16(bclk_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_BCLK_CTRL);
        IDX_TX_RATE: tx_rate_d = merge16(tx_rate_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_RATE);
        IDX_TX_CTRL: tx_ctrl_d = merge16(tx_ctrl_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_TX_CTRL);
        IDX_RX_RATE: rx_rate_d = merge16(rx_rate_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_RATE);
        IDX_RX_CTRL: rx_ctrl_d = merge16(rx_ctrl_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_RX_CTRL);
        IDX_CHAN_EN: chan_en_d = merge16(chan_en_q, S_AXI_WDATA_I, S_AXI_WSTRB_I, MSK_CHAN_EN);
        IDX_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_DECERR;
      endcase
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    case (rd_idx)
      IDX_BCLK_CTRL: rd_val = bclk_q;
      IDX_TX_RATE: rd_val = tx_rate_q;
      IDX_TX_CTRL: rd_val = tx_ctrl_q;
      IDX_RX_RATE: rd_val = rx_rate_q;
      IDX_RX_CTRL: rd_val = rx_ctrl_q;
      IDX_CHAN_EN: rd_val = chan_en_q;
      IDX_STATUS: rd_val = {12'h000, rx_drive, tx_drive, rx_fs, tx_fs};
      default:
      begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
    rvalid_d = rvalid_q && !S_AXI_RREADY_I;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_take)
    begin
      rvalid_d = 1'b1;
      rdata_d = {16'h0000, rd_val};
      rresp_d = rd_hit ? RESP_OKAY : RESP_DECERR;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      bclk_q <= RST_BCLK_CTRL;
      tx_rate_q <= RST_TX_RATE;
      tx_ctrl_q <= RST_TX_CTRL;
      rx_rate_q <= RST_RX_RATE;
      rx_ctrl_q <= RST_RX_CTRL;
      chan_en_q <= RST_CHAN_EN;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      bclk_q <= bclk_d;
      tx_rate_q <= tx_rate_d;
      tx_ctrl_q <= tx_ctrl_d;
      rx_rate_q <= rx_rate_d;
      rx_ctrl_q <= rx_ctrl_d;
      chan_en_q <= chan_en_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Pin inputs cross in from the outside world
  aafc_sync2 u_sync_bclk (.clk_i(CORE_CLK_I), .rst_i(SYS_RST_I), .d_i(SECOND_BIT_CLOCK_I), .q_o(bclk_pin_s));
  aafc_sync2 u_sync_tx (.clk_i(CORE_CLK_I), .rst_i(SYS_RST_I), .d_i(TX_FRAME_CLOCK_I), .q_o(tx_pin_s));
  aafc_sync2 u_sync_rx (.clk_i(CORE_CLK_I), .rst_i(SYS_RST_I), .d_i(RX_FRAME_CLOCK_I), .q_o(rx_pin_s));

  // Master clock is the core clock; code 0000 gives no usable bit clock edge
  assign bclk_div_n = BCLK_DIV_TABLE[bclk_q.divider];

  aafc_div #(.W(BDIV_W)) u_bclk_div (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .adv_i(1'b1),
    .div_i(bclk_div_n),
    .tick_o(bdiv_tick),
    .level_o(bdiv_level)
  );

  // External bit clock is only usable below half the core rate
  assign ext_rise = bclk_pin_s && !bclk_prev_q;
  assign bit_tick = bclk_q.master ? bdiv_tick : ext_rise;

  aafc_div #(.W(RATE_W)) u_tx_div (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .adv_i(bit_tick),
    .div_i(tx_rate_q[RATE_W-1:0]),
    .tick_o(),
    .level_o(tx_gen)
  );

  aafc_div #(.W(RATE_W)) u_rx_div (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .adv_i(bit_tick),
    .div_i(rx_rate_q[RATE_W-1:0]),
    .tick_o(),
    .level_o(rx_gen)
  );

  always_comb
  begin
    chan_any = |chan_en_q[1:0];
    tx_drive = (tx_ctrl_q.master && chan_any) || tx_ctrl_q.force_out;
    rx_drive = (rx_ctrl_q.master && chan_any) || rx_ctrl_q.force_out;
    // Slave sense follows the pin unless the device drives it itself
    tx_fs = (tx_drive ? tx_gen : tx_pin_s) ^ tx_ctrl_q.invert;
    rx_fs = (rx_drive ? rx_gen : rx_pin_s) ^ rx_ctrl_q.invert;
    tx_sync_d = tx_ctrl_q.src_sel ? rx_fs : tx_fs;
    rx_sync_d = rx_fs;
    bclk_pin_d = '{o: bdiv_level, oe_n: !bclk_q.master};
    tx_pin_d = '{o: tx_gen ^ tx_ctrl_q.invert, oe_n: !tx_drive};
    rx_pin_d = '{o: rx_gen ^ rx_ctrl_q.invert, oe_n: !rx_drive};
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      bclk_prev_q <= 1'b0;
      bclk_pin_q <= '{o: 1'b0, oe_n: 1'b1};
      tx_pin_q <= '{o: 1'b0, oe_n: 1'b1};
      rx_pin_q <= '{o: 1'b0, oe_n: 1'b1};
      tx_sync_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end
    else
    begin
      bclk_prev_q <= bclk_pin_s;
      bclk_pin_q <= bclk_pin_d;
      tx_pin_q <= tx_pin_d;
      rx_pin_q <= rx_pin_d;
      tx_sync_q <= tx_sync_d;
      rx_sync_q <= rx_sync_d;
    end
  end

  assign SECOND_BIT_CLOCK_O = bclk_pin_q.o;
  assign SECOND_BIT_CLOCK_OE_N_O = bclk_pin_q.oe_n;
  assign TX_FRAME_CLOCK_O = tx_pin_q.o;
  assign TX_FRAME_CLOCK_OE_N_O = tx_pin_q.oe_n;
  assign RX_FRAME_CLOCK_O = rx_pin_q.o;
  assign RX_FRAME_CLOCK_OE_N_O = rx_pin_q.oe_n;
  assign TX_SYNC_O = tx_sync_q;
  assign RX_SYNC_O = rx_sync_q;

  // Period check helper; a divider change voids the period in flight
  logic [7:0] bper_q;
  logic [7:0] bper_d;
  logic bchg_q;
  logic bchg_d;

  always_comb
  begin
    bper_d = bdiv_tick ? 8'h00 : bper_q + 8'h01;
    bchg_d = (bclk_d.divider != bclk_q.divider) || (bchg_q && !bdiv_tick);
  end

  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      bper_q <= 8'h00;
      bchg_q <= 1'b1;
    end
    else
    begin
      bper_q <= bper_d;
      bchg_q <= bchg_d;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  property p_bclk_mid;
    (bclk_q.divider inside {4'h8, 4'h9, 4'ha} && bclk_q.master && bdiv_tick && !bchg_q)
      |-> (bper_q == ((bclk_q.divider == 4'h8) ? 8'h17 : (bclk_q.divider == 4'h9) ? 8'h1f : 8'h2f));
  endproperty
  a_bclk_mid: assert property (p_bclk_mid) else $error("Wrong bit clock divisor for 1000-1010");

  property p_bclk_top;
    (bclk_q.divider[3:2] == 2'b11 && bclk_q.master && bdiv_tick && !bchg_q) |-> (bper_q == 8'h5f);
  endproperty
  a_bclk_top: assert property (p_bclk_top) else $error("Bit clock period is not 96 master clocks");

  property p_tx_force;
    tx_ctrl_q.force_out |=> !TX_FRAME_CLOCK_OE_N_O;
  endproperty
  a_tx_force: assert property (p_tx_force) else $error("Forced transmit frame clock not driven");

  property p_tx_slave;
    (!tx_ctrl_q.master && !tx_ctrl_q.force_out) |=> TX_FRAME_CLOCK_OE_N_O;
  endproperty
  a_tx_slave: assert property (p_tx_slave) else $error("Slave transmit frame pin driven");

  property p_tx_inv;
    !TX_FRAME_CLOCK_OE_N_O |-> (TX_FRAME_CLOCK_O == ($past(tx_gen) ^ $past(tx_ctrl_q.invert)));
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("Transmit frame clock polarity wrong");

  property p_rx_inv;
    !RX_FRAME_CLOCK_OE_N_O |-> (RX_FRAME_CLOCK_O == ($past(rx_gen) ^ $past(rx_ctrl_q.invert)));
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("Receive frame clock polarity wrong");

  property p_rx_master_idle;
    (rx_ctrl_q.master && chan_en_q[1:0] == 2'b00 && !rx_ctrl_q.force_out) |=> RX_FRAME_CLOCK_OE_N_O;
  endproperty
  a_rx_master_idle: assert property (p_rx_master_idle) else $error("Receive clock out with channels off");

  property p_rx_slave;
    (!rx_ctrl_q.master && !rx_ctrl_q.force_out) |=> RX_FRAME_CLOCK_OE_N_O;
  endproperty
  a_rx_slave: assert property (p_rx_slave) else $error("Slave receive frame pin driven");

  property p_rx_force;
    rx_ctrl_q.force_out |=> !RX_FRAME_CLOCK_OE_N_O;
  endproperty
  a_rx_force: assert property (p_rx_force) else $error("Forced receive frame clock not driven");

  property p_tx_src;
    ##1 TX_SYNC_O == ($past(tx_ctrl_q.src_sel) ? $past(rx_fs) : $past(tx_fs));
  endproperty
  a_tx_src: assert property (p_tx_src) else $error("Transmit sync from wrong source");
endmodule
`default_nettype wire

//--- design/aafc_pkg.sv
// Shared constants, register map and control layouts for the frame clock generator
// Summary of operation
// - Bit-clock divider codes 1000, 1001, 1010 divide the master clock by 24, 32, 48.
// - Bit-clock divider codes 1100 through 1111 all divide the master clock by 96.
// - Transmit frame clock is bit clock divided by 11-bit transmit rate, reset 080h.
// - Receive frame clock is bit clock divided by 11-bit receive rate, reset 080h.
// - Transmit path uses its own frame clock when select is 0, receive clock when 1.
// - Transmit invert bit 2 leaves frame clock normal at 0 and inverts it at 1.
// - Transmit force bit drives transmit frame clock always, in master and slave modes.
// - A running bit clock, internal or external, is needed for any frame clock output.
// - Transmit master bit 0 at 0 makes the pin an input unless forced; at 1 device drives it while a channel is enabled.
// - Receive invert bit 2 leaves frame clock normal at 0 and inverts it at 1.
// - Receive master mode without force outputs frame clock only while a channel is enabled.
// - Receive slave mode without force keeps the frame clock driver off so others may drive it.
// - Receive force bit generates receive frame clock always, in master and slave modes.
package aafc_pkg;

  localparam int AXI_AW = 12;
  localparam int RATE_W = 11;
  localparam int BDIV_W = 7;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_BCLK_CTRL = 10'h321;
  localparam logic [9:0] IDX_TX_RATE = 10'h322;
  localparam logic [9:0] IDX_TX_CTRL = 10'h323;
  localparam logic [9:0] IDX_RX_RATE = 10'h324;
  localparam logic [9:0] IDX_RX_CTRL = 10'h325;
  localparam logic [9:0] IDX_CHAN_EN = 10'h326;
  localparam logic [9:0] IDX_STATUS = 10'h327;

  localparam logic [15:0] RST_BCLK_CTRL = 16'h0000;
  localparam logic [15:0] RST_TX_RATE = 16'h0080;
  localparam logic [15:0] RST_TX_CTRL = 16'h0008;
  localparam logic [15:0] RST_RX_RATE = 16'h0080;
  localparam logic [15:0] RST_RX_CTRL = 16'h0000;
  localparam logic [15:0] RST_CHAN_EN = 16'h0000;

  // Writable bits; reserved bits read as zero
  localparam logic [15:0] MSK_BCLK_CTRL = 16'h010f;
  localparam logic [15:0] MSK_RATE = 16'h07ff;
  localparam logic [15:0] MSK_TX_CTRL = 16'h000f;
  localparam logic [15:0] MSK_RX_CTRL = 16'h0007;
  localparam logic [15:0] MSK_CHAN_EN = 16'h0003;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // Master clock divisor per bit-clock divider code
  localparam logic [BDIV_W-1:0] BCLK_DIV_TABLE [16] = '{
    7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h08, 7'h0c, 7'h10,
    7'h18, 7'h20, 7'h30, 7'h40, 7'h60, 7'h60, 7'h60, 7'h60};

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic master;
    logic [3:0] rsvd_lo;
    logic [3:0] divider;
  } aafc_bclk_ctrl_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic src_sel;
    logic invert;
    logic force_out;
    logic master;
  } aafc_fc_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe_n;
  } aafc_pin_t;

endpackage

//--- design/aafc_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module aafc_sync2 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

//--- design/aafc_div.sv
// Counting divider: one period every div_i advances, high for the first half
`timescale 1ns/1ps
`default_nettype none
module aafc_div
  import aafc_pkg::*;
#(
  parameter int W = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic adv_i,
  input wire logic [W-1:0] div_i,
  output logic tick_o,
  output logic level_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic last;

  always_comb
  begin
    // A zero divisor never ends a period and holds the level low, so no edges come out
    last = (div_i != '0) && (cnt_q >= div_i - W'(1));
    cnt_d = cnt_q;
    if (adv_i)
    begin
      cnt_d = last ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = adv_i && last;
  assign level_o = (div_i != '0) && (cnt_q < (div_i >> 1));

  property p_period_restart;
    @(posedge clk_i) disable iff (rst_i)
    (adv_i && div_i != '0 && cnt_q == div_i - W'(1)) |=> (cnt_q == '0);
  endproperty
  a_period_restart: assert property (p_period_restart) else $error("Divider did not restart at boundary");

  property p_hold_no_adv;
    @(posedge clk_i) disable iff (rst_i)
    (!adv_i) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_hold_no_adv: assert property (p_hold_no_adv) else $error("Divider moved without a bit tick");
endmodule
`default_nettype wire

//--- verif/aafc_host_port.sv
// Host audio port model: external bit clock and host-side frame clocks
`timescale 1ns/1ps
`default_nettype none
module aafc_host_port (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  input wire logic bclk_i,
  input wire logic bclk_oe_n_i,
  input wire logic tx_i,
  input wire logic tx_oe_n_i,
  input wire logic rx_i,
  input wire logic rx_oe_n_i,
  output logic bclk_o,
  output logic tx_o,
  output logic rx_o
);
  logic [7:0] cnt_q = 8'h00;
  logic [2:0] fcnt_q = 3'h0;
  logic bclk_q = 1'b0;
  logic junk_q = 1'b0;
  logic host_fc;
  // Bit clock stands still while stopped, so no frame can advance
  always_ff @(posedge clk_i)
  begin
    junk_q <= ~junk_q;
    if (!run_i)
    begin
      cnt_q <= 8'h00;
      bclk_q <= 1'b0;
    end
    else if (cnt_q == half_i - 8'h01)
    begin
      cnt_q <= 8'h00;
      bclk_q <= ~bclk_q;
      fcnt_q <= fcnt_q + {2'b00, ~bclk_q};
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  // Released frame clock pins show a changing pattern, never a stale level
  assign host_fc = run_i ? fcnt_q[2] : junk_q;
  assign bclk_o = bclk_oe_n_i ? bclk_q : bclk_i;
  assign tx_o = tx_oe_n_i ? host_fc : tx_i;
  assign rx_o = rx_oe_n_i ? host_fc : rx_i;
endmodule
`default_nettype wire

//--- verif/aux_audio_frame_clock_gen_test.sv
// Self-checking bench for the frame clock generator
`timescale 1ns/1ps
`default_nettype none
module aux_audio_frame_clock_gen_test
  import aafc_pkg::*;
;
  typedef struct packed {logic [9:0] idx; logic [15:0] wd; logic [15:0] rd;} aafc_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, run = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, bck_i, bck_o, bck_oe, txi, txo, txoe, rxi, rxo, rxoe, txs, rxs;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int num_checks = 0;
  int x;
  logic [3:0] codes [5] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hf};
  int divs [5] = '{24, 32, 48, 96, 96};
  aafc_row_t rows [8] = '{
    '{IDX_TX_RATE, 16'hffff, 16'h07ff}, '{IDX_TX_RATE, 16'h0009, 16'h0009},
    '{IDX_RX_RATE, 16'hf955, 16'h0155}, '{IDX_RX_RATE, 16'h000b, 16'h000b},
    '{IDX_TX_CTRL, 16'hfff0, 16'h0000}, '{IDX_RX_CTRL, 16'hffff, 16'h0007},
    '{IDX_CHAN_EN, 16'hfffc, 16'h0000}, '{IDX_BCLK_CTRL, 16'hfeff, 16'h000f}};

  aafc_top i_aafc_top (.CORE_CLK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
    .SECOND_BIT_CLOCK_I(bck_i), .SECOND_BIT_CLOCK_O(bck_o), .SECOND_BIT_CLOCK_OE_N_O(bck_oe),
    .TX_FRAME_CLOCK_I(txi), .TX_FRAME_CLOCK_O(txo), .TX_FRAME_CLOCK_OE_N_O(txoe),
    .RX_FRAME_CLOCK_I(rxi), .RX_FRAME_CLOCK_O(rxo), .RX_FRAME_CLOCK_OE_N_O(rxoe),
    .TX_SYNC_O(txs), .RX_SYNC_O(rxs));

  aafc_host_port i_aafc_host_port (.clk_i(clk), .run_i(run), .half_i(8'h08),
    .bclk_i(bck_o), .bclk_oe_n_i(bck_oe), .tx_i(txo), .tx_oe_n_i(txoe), .rx_i(rxo), .rx_oe_n_i(rxoe),
    .bclk_o(bck_i), .tx_o(txi), .rx_o(rxi));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] rsp);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while ((awready & wready) !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, rsp});
    repeat (3) @(posedge clk);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [15:0] exp, input logic [1:0] rsp);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {16'h0000, exp});
    chk({30'h0, rresp}, {30'h0, rsp});
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return bck_o;
      1: return txo;
      2: return rxo;
      3: return txs;
      default: return rxs;
    endcase
  endfunction

  // Bounded wait while a signal keeps one level
  task automatic wt(input int s, input logic v, inout int c);
    int n;
    n = 0;
    while (sig(s) === v && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
    c = c + n;
  endtask

  // Skips a partial period first, since config writes land mid-count
  task automatic meas(input int s, input int per_e, input int hi_e);
    int y, hi, lo;
    y = 0;
    hi = 0;
    lo = 0;
    wt(s, 1'b1, y);
    wt(s, 1'b0, y);
    wt(s, 1'b1, hi);
    wt(s, 1'b0, lo);
    chk(hi + lo, per_e);
    if (hi_e > 0)
      chk(hi, hi_e);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk(IDX_TX_RATE, RST_TX_RATE, RESP_OKAY);
    rdchk(IDX_RX_RATE, RST_RX_RATE, RESP_OKAY);
    rdchk(IDX_TX_CTRL, RST_TX_CTRL, RESP_OKAY);
    wr(10'h3f0, 16'hffff, RESP_DECERR);
    rdchk(10'h3f0, 16'h0000, RESP_DECERR);
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wd, RESP_OKAY);
      rdchk(rows[i].idx, rows[i].rd, RESP_OKAY);
    end
    $display("Test registers done");
    foreach (codes[i])
    begin
      wr(IDX_BCLK_CTRL, {8'h01, 4'h0, codes[i]}, RESP_OKAY);
      meas(0, divs[i], 0);
    end
    $display("Test bit clock done");
    wr(IDX_BCLK_CTRL, 16'h0108, RESP_OKAY);
    wr(IDX_TX_CTRL, 16'h0001, RESP_OKAY);
    wr(IDX_RX_CTRL, 16'h0001, RESP_OKAY);
    wr(IDX_CHAN_EN, 16'h0003, RESP_OKAY);
    meas(1, 216, 96);
    meas(2, 264, 120);
    meas(4, 264, 120);
    meas(3, 216, 96);
    chk({29'h0, bck_oe, txoe, rxoe}, 32'h0);
    wr(IDX_TX_CTRL, 16'h0005, RESP_OKAY);
    meas(1, 216, 120);
    wr(IDX_RX_CTRL, 16'h0005, RESP_OKAY);
    meas(2, 264, 144);
    wr(IDX_TX_CTRL, 16'h000d, RESP_OKAY);
    meas(3, 264, 144);
    $display("Test master frames done");
    wr(IDX_CHAN_EN, 16'h0000, RESP_OKAY);
    chk({30'h0, txoe, rxoe}, 32'h3);
    wr(IDX_TX_CTRL, 16'h0003, RESP_OKAY);
    wr(IDX_RX_CTRL, 16'h0003, RESP_OKAY);
    chk({30'h0, txoe, rxoe}, 32'h0);
    meas(1, 216, 96);
    meas(2, 264, 120);
    $display("Test forced output done");
    wr(IDX_BCLK_CTRL, 16'h0008, RESP_OKAY);
    wr(IDX_TX_CTRL, 16'h0002, RESP_OKAY);
    wr(IDX_RX_CTRL, 16'h0000, RESP_OKAY);
    run <= 1'b1;
    meas(1, 144, 64);
    chk({29'h0, bck_oe, txoe, rxoe}, 32'h5);
    wr(IDX_TX_CTRL, 16'h000a, RESP_OKAY);
    meas(3, 128, 64);
    @(posedge clk);
    run <= 1'b0;
    repeat (20) @(posedge clk);
    x = 0;
    wt(1, txo, x);
    chk(x, 5000);
    $display("Test slave bit clock done");
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({29'h0, bck_oe, txoe, rxoe}, 32'h7);
    rdchk(IDX_TX_CTRL, RST_TX_CTRL, RESP_OKAY);
    rdchk(IDX_RX_RATE, RST_RX_RATE, RESP_OKAY);
    $display("Test mid-run reset done");
    end_sim();
  end
endmodule
`default_nettype wire
